// File: verilog/superio_config_space.v
/*
 * Configuration space: index/data port pair, chip-level registers
 * 0x07, 0x26, 0x27, 0x2a-0x2f and eight banks of per-unit registers.
 * Assumes host I/O cycles arrive already decoded from the host bus as
 * one-cycle read and write strobes on ref_clk, and that the reset
 * sources other than rstn are one-cycle pulses on the same clock.
 */
`timescale 1ns/1ns
`include "superio_cfg_regs.vh"
module superio_config_space
(
    ref_clk,
    rstn,
    standby_power_on_reset,
    hard_reset,
    soft_reset,

    config_state,
    addr_strap,

    io_addr,
    io_wr,
    io_rd,
    io_wdata,
    io_hit,
    io_rdata,
    io_rdata_vld,

    pwr_ctrl_we,
    pwr_ctrl_wdata,

    kbc_reset,
    cfg_port_addr,
    unit_number,
    unit_active,
    unit_base0,
    kbc_base1,
    unit_irq_sel,
    kbc_irq_sel2,
    unit_irq_edge_high
);
    input  wire         ref_clk;
    input  wire         rstn;
    input  wire         standby_power_on_reset;
    input  wire         hard_reset;
    input  wire         soft_reset;

    input  wire         config_state;
    input  wire         addr_strap;

    input  wire [15:0]  io_addr;
    input  wire         io_wr;
    input  wire         io_rd;
    input  wire [7:0]   io_wdata;
    output wire         io_hit;
    output reg  [7:0]   io_rdata;
    output reg          io_rdata_vld;

    input  wire         pwr_ctrl_we;
    input  wire [7:0]   pwr_ctrl_wdata;

    output wire         kbc_reset;
    output wire [15:0]  cfg_port_addr;
    output wire [7:0]   unit_number;
    output wire [7:0]   unit_active;
    output wire [127:0] unit_base0;
    output wire [15:0]  kbc_base1;
    output wire [63:0]  unit_irq_sel;
    output wire [7:0]   kbc_irq_sel2;
    output reg  [7:0]   unit_irq_edge_high;

    reg  [7:0]   test_reg_f_ff;
    reg  [7:0]   test_reg_d_ff;
    reg  [7:0]   test_kbc_reset_ctrl_ff;
    reg  [7:0]   test_reg_a_ff;
    reg  [7:0]   test_reg_b_ff;
    reg  [7:0]   test_reg_c_ff;
    reg  [15:0]  cfg_addr_ff;
    reg  [7:0]   cfg_low_pend_ff;
    reg  [7:0]   index_ff;
    reg  [7:0]   unit_num_ff;
    reg  [7:0]   nxt_rdata;
    wire         strap_lvl;
    wire [15:0]  strap_addr;
    wire         clr_test;
    wire         clr_cfg;
    wire         clr_all;
    wire         hit_index;
    wire         hit_data;
    wire         data_wr;
    wire         data_rd;
    wire         unit_space;
    wire         unit_ok;
    wire [2:0]   bank;
    wire [63:0]  bank_rdata;
    wire [7:0]   sel_rdata;
    wire [15:0]  base1_all [0:7];
    wire [7:0]   irq2_all [0:7];
    wire         test_idx;
    reg  [7:0]   test_rdata;
    wire         index_wr;
    wire         index_rd;

    // Reset groups differ by register class
    assign clr_test = ~rstn | standby_power_on_reset;
    assign clr_cfg  = ~rstn | hard_reset;
    assign clr_all  = ~rstn | standby_power_on_reset
                    | hard_reset | soft_reset;

    strap_sync u_strap
    (
        .ref_clk (ref_clk),
        .d       (addr_strap),
        .q       (strap_lvl)
    );

    assign strap_addr = strap_lvl ? `CFG_ADDR_STRAP_HIGH
                                  : `CFG_ADDR_STRAP_LOW;

    // Only the current pair decodes, so the old pair goes quiet
    assign hit_index = (io_addr == cfg_addr_ff);
    assign hit_data  = (io_addr == (cfg_addr_ff | 16'h0001));
    assign io_hit    = (io_wr | io_rd) & (hit_index | hit_data);
    assign data_wr   = io_wr & hit_data;
    assign data_rd   = io_rd & hit_data;
    assign index_wr  = io_wr & hit_index;
    assign index_rd  = io_rd & hit_index;

    // Index port write only selects; the data port does the access
    always @(posedge ref_clk)
    begin
        if (clr_all)
        begin
            index_ff <= 8'h00;
        end
        else if (index_wr)
        begin
            index_ff <= io_wdata;
        end
    end

    always @(posedge ref_clk)
    begin
        if (clr_all)
        begin
            unit_num_ff <= `RST_UNIT_NUMBER;
        end
        else if (data_wr && index_ff == `IDX_UNIT_NUMBER)
        begin
            unit_num_ff <= io_wdata;
        end
    end

    // Numbers above the last bank select nothing and read zero
    assign bank       = unit_num_ff[2:0];
    assign unit_space = (index_ff >= `IDX_UNIT_FIRST);
    assign unit_ok    = unit_space & config_state
                      & (unit_num_ff[7:3] == 5'h00);

    // Relocation: held low byte commits with the high byte write
    always @(posedge ref_clk)
    begin
        if (clr_cfg)
        begin
            cfg_addr_ff     <= strap_addr;
            cfg_low_pend_ff <= strap_addr[7:0];
        end
        else if (data_wr && index_ff == `IDX_CFG_ADDR_LOW)
        begin
            cfg_low_pend_ff <= {io_wdata[7:1], 1'b0};
        end
        else if (data_wr && index_ff == `IDX_CFG_ADDR_HIGH)
        begin
            cfg_addr_ff <= {io_wdata, cfg_low_pend_ff};
        end
    end

    assign cfg_port_addr = cfg_addr_ff;

    // Test registers: plain storage except 0x2c bit 6, which drives kbc_reset; no test mode is acted upon
    assign test_idx = (index_ff >= `IDX_TEST_FIRST)
                    & (index_ff <= `IDX_TEST_LAST);

    // Only the two power-on resets clear them; hard and soft keep them
    always @(posedge ref_clk)
    begin
        if (clr_test)
        begin
            test_reg_f_ff          <= `RST_TEST;
            test_reg_d_ff          <= `RST_TEST;
            test_kbc_reset_ctrl_ff <= `RST_TEST;
            test_reg_a_ff          <= `RST_TEST;
            test_reg_b_ff          <= `RST_TEST;
            test_reg_c_ff          <= `RST_TEST;
        end
        else if (data_wr)
        begin
            case (index_ff)
                `IDX_TEST_FIRST: test_reg_f_ff          <= io_wdata;
                `IDX_TEST_D:     test_reg_d_ff          <= io_wdata;
                `IDX_TEST_KBC:   test_kbc_reset_ctrl_ff <= io_wdata;
                `IDX_TEST_A:     test_reg_a_ff          <= io_wdata;
                `IDX_TEST_B:     test_reg_b_ff          <= io_wdata;
                `IDX_TEST_LAST:  test_reg_c_ff          <= io_wdata;
                default:         ;
            endcase
        end
    end

    // Kept apart so the data port mux stays shallow
    always @*
    begin
        test_rdata = 8'h00;
        case (index_ff)
            `IDX_TEST_FIRST: test_rdata = test_reg_f_ff;
            `IDX_TEST_D:     test_rdata = test_reg_d_ff;
            `IDX_TEST_KBC:   test_rdata = test_kbc_reset_ctrl_ff;
            `IDX_TEST_A:     test_rdata = test_reg_a_ff;
            `IDX_TEST_B:     test_rdata = test_reg_b_ff;
            `IDX_TEST_LAST:  test_rdata = test_reg_c_ff;
            default:         test_rdata = 8'h00;
        endcase
    end

    assign kbc_reset = test_kbc_reset_ctrl_ff[`KBC_RESET_BIT];

    genvar g;
    generate
        for (g = 0; g < `NUM_UNITS; g = g + 1)
        begin : g_unit
            wire [7:0] rd;
            unit_bank
            #(
                .TWO_BASES (g == `KBC_UNIT),
                .HAS_IRQ2  (g == `KBC_UNIT),
                .IRQ0_RST  ((g == 0) ? `RST_IRQ_UNIT0 : `RST_IRQ_OTHER)
            )
            u_bank
            (
                .ref_clk (ref_clk),
                .clr     (clr_all),
                .sel     (unit_ok && bank == g),
                .wr      (data_wr),
                .idx     (index_ff),
                .wdata   (io_wdata),
                .pwr_we  (pwr_ctrl_we),
                .pwr_bit (pwr_ctrl_wdata[g]),
                .rdata   (rd),
                .active  (unit_active[g]),
                .base0   (unit_base0[g*16 +: 16]),
                .base1   (base1_all[g]),
                .irq0    (unit_irq_sel[g*8 +: 8]),
                .irq1    (irq2_all[g])
            );
            assign bank_rdata[g*8 +: 8] = rd;
        end
    endgenerate

    assign kbc_base1    = base1_all[`KBC_UNIT];
    assign kbc_irq_sel2 = irq2_all[`KBC_UNIT];
    assign sel_rdata    = bank_rdata[bank*8 +: 8];

    // Unmapped chip-level and unit indices read zero; the bank
    // returns zero for 0x31-0x5f, unused bases and 0x71/0x73
    always @*
    begin
        nxt_rdata = 8'h00;
        if (unit_space)
        begin
            if (unit_ok)
                nxt_rdata = sel_rdata;
        end
        else if (test_idx)
        begin
            nxt_rdata = test_rdata;
        end
        else
        begin
            case (index_ff)
                `IDX_UNIT_NUMBER:   nxt_rdata = unit_num_ff;
                `IDX_CFG_ADDR_LOW:  nxt_rdata = cfg_addr_ff[7:0];
                `IDX_CFG_ADDR_HIGH: nxt_rdata = cfg_addr_ff[15:8];
                default:            nxt_rdata = 8'h00;
            endcase
        end
    end

    // Read data is registered: answer follows the strobe by one edge
    always @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            io_rdata     <= 8'h00;
            io_rdata_vld <= 1'b0;
        end
        else
        begin
            io_rdata_vld <= data_rd | index_rd;
            if (data_rd)
            begin
                io_rdata <= nxt_rdata;
            end
            else if (index_rd)
            begin
                io_rdata <= index_ff;
            end
        end
    end

    // Interrupt signalling type is fixed; one flag per unit
    always @(posedge ref_clk)
    begin
        if (clr_all)
        begin
            unit_irq_edge_high <= 8'hff;
        end
        else
        begin
            unit_irq_edge_high <= 8'hff;
        end
    end

    assign unit_number = unit_num_ff;
endmodule

// File: verilog/superio_cfg_regs.vh
/*
 * Index map, field positions and reset values of the configuration space.
 * Assumes an 8-bit index port followed by the data port at index port + 1.
 */
`ifndef SUPERIO_CFG_REGS_VH
`define SUPERIO_CFG_REGS_VH

`define IDX_UNIT_NUMBER      8'h07
`define IDX_CFG_ADDR_LOW     8'h26
`define IDX_CFG_ADDR_HIGH    8'h27
`define IDX_TEST_FIRST       8'h2a
`define IDX_TEST_LAST        8'h2f
`define IDX_TEST_KBC         8'h2c
`define IDX_TEST_D           8'h2b
`define IDX_TEST_A           8'h2d
`define IDX_TEST_B           8'h2e
`define IDX_UNIT_FIRST       8'h30
`define IDX_ACTIVATE         8'h30
`define IDX_BASE0_HIGH       8'h60
`define IDX_BASE0_LOW        8'h61
`define IDX_BASE1_HIGH       8'h62
`define IDX_BASE1_LOW        8'h63
`define IDX_IRQ_PRIMARY      8'h70
`define IDX_IRQ_SECONDARY    8'h72

`define KBC_RESET_BIT        6
`define ACTIVATE_BIT         0
`define NUM_UNITS            8
`define KBC_UNIT             3'h4

`define CFG_ADDR_STRAP_LOW   16'h002e
`define CFG_ADDR_STRAP_HIGH  16'h004e
`define RST_TEST             8'h00
`define RST_ACTIVATE         8'h00
`define RST_BASE             8'h00
`define RST_IRQ_UNIT0        8'h06
`define RST_IRQ_OTHER        8'h00
`define RST_IRQ_SECONDARY    8'h00
`define RST_UNIT_NUMBER      8'h00

`endif

// File: verilog/strap_sync.v
/*
 * Two-flop synchroniser for a level from outside the clock domain.
 * Assumes the input is a slow level such as a strap pin.
 */
`timescale 1ns/1ns
module strap_sync
(
    ref_clk,
    d,
    q
);
    input  wire ref_clk;
    input  wire d;
    output wire q;

    reg         meta_ff;
    reg         sync_ff;

    // No reset: the pipe settles within two edges of any level
    always @(posedge ref_clk)
    begin
        meta_ff <= d;
        sync_ff <= meta_ff;
    end

    assign q = sync_ff;
endmodule

// File: verilog/unit_bank.v
/*
 * One bank of per-unit configuration registers (index 0x30 and up).
 * Assumes the caller qualifies sel with the configuration state and
 * the unit number, and registers rdata before it leaves the chip.
 */
`timescale 1ns/1ns
`include "superio_cfg_regs.vh"
module unit_bank
#(
    parameter       TWO_BASES = 0,
    parameter       HAS_IRQ2  = 0,
    parameter [7:0] IRQ0_RST  = `RST_IRQ_OTHER
)
(
    ref_clk,
    clr,
    sel,
    wr,
    idx,
    wdata,
    pwr_we,
    pwr_bit,
    rdata,
    active,
    base0,
    base1,
    irq0,
    irq1
);
    input  wire        ref_clk;
    input  wire        clr;
    input  wire        sel;
    input  wire        wr;
    input  wire [7:0]  idx;
    input  wire [7:0]  wdata;
    input  wire        pwr_we;
    input  wire        pwr_bit;
    output reg  [7:0]  rdata;
    output wire        active;
    output wire [15:0] base0;
    output wire [15:0] base1;
    output wire [7:0]  irq0;
    output wire [7:0]  irq1;

    reg         act_ff;
    reg  [15:0] base0_ff;
    reg  [15:0] base1_ff;
    reg  [7:0]  irq0_ff;
    reg  [7:0]  irq1_ff;
    wire        we;

    assign we = sel & wr;

    always @(posedge ref_clk)
    begin
        if (clr)
        begin
            act_ff   <= 1'b0;
            base0_ff <= {`RST_BASE, `RST_BASE};
            base1_ff <= {`RST_BASE, `RST_BASE};
            irq0_ff  <= IRQ0_RST;
            irq1_ff  <= `RST_IRQ_SECONDARY;
        end
        else
        begin
            // Power-control write and activate write share one flop
            if (we && idx == `IDX_ACTIVATE)
                act_ff <= wdata[`ACTIVATE_BIT];
            else if (pwr_we)
                act_ff <= pwr_bit;
            if (we && idx == `IDX_BASE0_HIGH)
                base0_ff[15:8] <= wdata;
            if (we && idx == `IDX_BASE0_LOW)
                base0_ff[7:0] <= wdata;
            if (TWO_BASES != 0 && we && idx == `IDX_BASE1_HIGH)
                base1_ff[15:8] <= wdata;
            if (TWO_BASES != 0 && we && idx == `IDX_BASE1_LOW)
                base1_ff[7:0] <= wdata;
            if (we && idx == `IDX_IRQ_PRIMARY)
                irq0_ff <= wdata;
            if (HAS_IRQ2 != 0 && we && idx == `IDX_IRQ_SECONDARY)
                irq1_ff <= wdata;
        end
    end

    always @*
    begin
        rdata = 8'h00;
        case (idx)
            `IDX_ACTIVATE:       rdata = {7'h00, act_ff};
            `IDX_BASE0_HIGH:     rdata = base0_ff[15:8];
            `IDX_BASE0_LOW:      rdata = base0_ff[7:0];
            `IDX_BASE1_HIGH:     rdata = (TWO_BASES != 0) ? base1_ff[15:8] : 8'h00;
            `IDX_BASE1_LOW:      rdata = (TWO_BASES != 0) ? base1_ff[7:0] : 8'h00;
            `IDX_IRQ_PRIMARY:    rdata = irq0_ff;
            `IDX_IRQ_SECONDARY:  rdata = (HAS_IRQ2 != 0) ? irq1_ff : 8'h00;
            default:             rdata = 8'h00;
        endcase
    end

    assign active = act_ff;
    assign base0  = base0_ff;
    assign base1  = (TWO_BASES != 0) ? base1_ff : 16'h0000;
    assign irq0   = irq0_ff;
    assign irq1   = (HAS_IRQ2 != 0) ? irq1_ff : 8'h00;
endmodule

// File: test/superio_cfg_properties.sv
/* Port checks for the configuration space.
   Assumes the port names and widths of superio_config_space. */
`timescale 1ns/1ns
module cfg_checker
(
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        standby_power_on_reset,
    input wire logic        hard_reset,
    input wire logic        soft_reset,
    input wire logic        config_state,
    input wire logic [15:0] io_addr,
    input wire logic        io_wr,
    input wire logic        io_rd,
    input wire logic [7:0]  io_wdata,
    input wire logic        io_hit,
    input wire logic [7:0]  io_rdata,
    input wire logic        io_rdata_vld,
    input wire logic        pwr_ctrl_we,
    input wire logic [7:0]  pwr_ctrl_wdata,
    input wire logic        kbc_reset,
    input wire logic [15:0] cfg_port_addr,
    input wire logic [7:0]  unit_number,
    input wire logic [7:0]  unit_active
);
    wire        any_rst = !rstn || soft_reset || hard_reset || standby_power_on_reset;
    wire        dwr     = io_wr && io_addr == (cfg_port_addr | 16'h0001);
    wire        drd     = io_rd && io_addr == (cfg_port_addr | 16'h0001);
    logic [7:0] idx_ff;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (any_rst);
    // Index mirror, cleared by every reset like the design's own
    always @(posedge ref_clk)
        if (any_rst)
            idx_ff <= 8'h00;
        else if (io_wr && io_addr == cfg_port_addr)
            idx_ff <= io_wdata;
    a_read_answer: assert property (io_rd && io_hit |=> io_rdata_vld)
        else $error("read not answered");
    a_kbc_hold: assert property (dwr && idx_ff == 8'h2c |=> kbc_reset == $past(io_wdata[6]))
        else $error("kbc reset bit");
    a_bank_select: assert property (dwr && idx_ff == 8'h07 |=> unit_number == $past(io_wdata))
        else $error("unit number");
    a_cfg_move: assert property (dwr && idx_ff == 8'h27 |=> cfg_port_addr[15:8] == $past(io_wdata))
        else $error("config move");
    a_port_decode: assert property (io_hit == ((io_wr || io_rd) && io_addr[15:1] == cfg_port_addr[15:1]))
        else $error("port decode");
    a_gate_unit: assert property (drd && idx_ff >= 8'h30 && !config_state |=> io_rdata == 8'h00)
        else $error("ungated read");
    a_cfg_keep: assert property (disable iff (!rstn || hard_reset)
        (soft_reset || standby_power_on_reset) && !io_wr |=> $stable(cfg_port_addr))
        else $error("config address lost");
    a_power_link: assert property (pwr_ctrl_we && !dwr |=> unit_active == $past(pwr_ctrl_wdata))
        else $error("power link");
    cover property (dwr && idx_ff == 8'h27);
    cover property (drd && idx_ff == 8'h2c);
    cover property (pwr_ctrl_we);
endmodule
bind superio_config_space cfg_checker cfg_checker_inst
(
    .ref_clk(ref_clk), .rstn(rstn), .standby_power_on_reset(standby_power_on_reset),
    .hard_reset(hard_reset), .soft_reset(soft_reset), .config_state(config_state),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_hit(io_hit),
    .io_rdata(io_rdata), .io_rdata_vld(io_rdata_vld), .pwr_ctrl_we(pwr_ctrl_we),
    .pwr_ctrl_wdata(pwr_ctrl_wdata), .kbc_reset(kbc_reset), .cfg_port_addr(cfg_port_addr),
    .unit_number(unit_number), .unit_active(unit_active)
);

// File: test/host_model.sv
/* Host model: index/data port cycles as one-cycle strobes.
   Assumes the tb keeps port in step after a hard reset. */
`timescale 1ns/1ns
module host_model
(
    input  wire logic        ref_clk,
    output logic      [15:0] io_addr,
    output logic             io_wr,
    output logic             io_rd,
    output logic      [7:0]  io_wdata,
    input  wire logic [7:0]  io_rdata,
    input  wire logic        io_rdata_vld
);
    logic [15:0] port = 16'h002e;
    logic        v;
    initial
    begin
        {io_addr, io_wr, io_rd, io_wdata} = 26'h0;
    end
    task cyc(input logic [15:0] a, input logic [7:0] d, input logic w);
    begin
        @(posedge ref_clk);
        {io_addr, io_wdata, io_wr, io_rd} <= {a, d, w, !w};
        @(posedge ref_clk);
        // Released lines must not keep the last value
        {io_addr, io_wdata, io_wr, io_rd} <= {~a, ~d, 2'b00};
        #1;
    end
    endtask
    task rd(input logic [15:0] a, output logic [7:0] d, output logic vl);
    begin
        cyc(a, 8'h00, 1'b0);
        d = io_rdata;
        vl = io_rdata_vld;
    end
    endtask
    task wr_reg(input logic [7:0] i, input logic [7:0] d);
    begin
        cyc(port, i, 1'b1);
        cyc(port | 16'h0001, d, 1'b1);
    end
    endtask
    task rd_reg(input logic [7:0] i, output logic [7:0] d);
    begin
        cyc(port, i, 1'b1);
        rd(port | 16'h0001, d, v);
    end
    endtask
    task move(input logic [15:0] a);
    begin
        wr_reg(8'h26, {a[7:1], 1'b0});
        wr_reg(8'h27, a[15:8]);
        port = {a[15:1], 1'b0};
    end
    endtask
endmodule

// File: test/tb_top.sv
/* Bench: table of bank accesses, then power link, relocation, resets.
   Assumes host_model drives the host I/O cycles. */
`timescale 1ns/1ns
module tb_top;
    logic         ref_clk = 1'b0;
    logic         rstn = 1'b0;
    logic         sby = 1'b0;
    logic         hard_reset = 1'b0;
    logic         soft_reset = 1'b0;
    logic         config_state = 1'b1;
    logic         addr_strap = 1'b0;
    logic         pwr_ctrl_we = 1'b0;
    logic [7:0]   pwr_ctrl_wdata = 8'h00;
    wire  [15:0]  io_addr, cfg_port_addr, kbc_base1;
    wire  [7:0]   io_wdata, io_rdata, unit_number, unit_active, kbc_irq_sel2, irq_edge;
    wire          io_wr, io_rd, io_hit, io_rdata_vld, kbc_reset;
    wire  [127:0] unit_base0;
    wire  [63:0]  unit_irq_sel;
    int           n_mismatch = 0;
    int           checks = 0;
    int           i;
    logic [7:0]   d;
    logic         v;
    logic [31:0]  r;
    // Rows: unit, index, write data, read back
    logic [31:0]  rows [0:13] = '{
        32'h00300101, 32'h00601212, 32'h00613434,
        32'h00625500, 32'h04625656, 32'h04637878,
        32'h04720909, 32'h01720900, 32'h0231ff00,
        32'h025fff00, 32'h0371ff00, 32'h0373ff00,
        32'h056fff00, 32'h07700a0a};
    always #2 ref_clk = ~ref_clk;
    superio_config_space superio_config_space_inst
    (
        .ref_clk(ref_clk), .rstn(rstn), .standby_power_on_reset(sby),
        .hard_reset(hard_reset), .soft_reset(soft_reset), .config_state(config_state),
        .addr_strap(addr_strap), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_hit(io_hit), .io_rdata(io_rdata), .io_rdata_vld(io_rdata_vld),
        .pwr_ctrl_we(pwr_ctrl_we), .pwr_ctrl_wdata(pwr_ctrl_wdata), .kbc_reset(kbc_reset),
        .cfg_port_addr(cfg_port_addr), .unit_number(unit_number), .unit_active(unit_active),
        .unit_base0(unit_base0), .kbc_base1(kbc_base1), .unit_irq_sel(unit_irq_sel),
        .kbc_irq_sel2(kbc_irq_sel2), .unit_irq_edge_high(irq_edge)
    );
    host_model host_model_inst
    (
        .ref_clk(ref_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_vld(io_rdata_vld)
    );
    task chk(input logic [15:0] seen, input logic [15:0] exp);
    begin
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    end
    endtask
    task pulse(input int w);
    begin
        @(posedge ref_clk);
        {soft_reset, sby, hard_reset} <= {w == 0, w == 1, w == 2};
        @(posedge ref_clk);
        {soft_reset, sby, hard_reset} <= 3'b000;
        #1;
    end
    endtask
    task final_report;
    begin
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    // Whole run is a few hundred cycles
    initial
    begin
        #60000;
        n_mismatch++;
        final_report;
    end
    initial
    begin
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        #1;
        chk(cfg_port_addr, 16'h002e);
        chk(16'(unit_irq_sel[15:0]), 16'h0006);
        chk(16'(irq_edge), 16'h00ff);
        chk(16'(unit_active), 16'h0000);
        for (i = 'h2a; i <= 'h2f; i++)
        begin
            host_model_inst.rd_reg(8'(i), d);
            chk(16'(d), 16'h0000);
        end
        for (i = 0; i < 14; i++)
        begin
            r = rows[i];
            host_model_inst.wr_reg(8'h07, r[31:24]);
            host_model_inst.wr_reg(r[23:16], r[15:8]);
            host_model_inst.rd_reg(r[23:16], d);
            chk(16'(d), 16'(r[7:0]));
        end
        chk(unit_base0[79:64], 16'h0000);
        chk(kbc_base1, 16'h5678);
        chk(16'(kbc_irq_sel2), 16'h0009);
        host_model_inst.wr_reg(8'h2c, 8'h40);
        chk(16'(kbc_reset), 16'h0001);
        host_model_inst.rd_reg(8'h2c, d);
        chk(16'(d), 16'h0040);
        host_model_inst.wr_reg(8'h07, 8'h00);
        @(posedge ref_clk) config_state <= 1'b0;
        host_model_inst.wr_reg(8'h60, 8'hee);
        host_model_inst.rd_reg(8'h60, d);
        chk(16'(d), 16'h0000);
        @(posedge ref_clk) config_state <= 1'b1;
        host_model_inst.rd_reg(8'h60, d);
        chk(16'(d), 16'h0012);
        @(posedge ref_clk) {pwr_ctrl_we, pwr_ctrl_wdata} <= 9'h181;
        @(posedge ref_clk) pwr_ctrl_we <= 1'b0;
        #1;
        chk(16'(unit_active), 16'h0081);
        host_model_inst.wr_reg(8'h07, 8'h07);
        host_model_inst.wr_reg(8'h30, 8'h00);
        chk(16'(unit_active), 16'h0001);
        host_model_inst.move(16'h0370);
        chk(cfg_port_addr, 16'h0370);
        host_model_inst.rd(16'h002f, d, v);
        chk(16'(v), 16'h0000);
        host_model_inst.wr_reg(8'h07, 8'h02);
        chk(16'(unit_number), 16'h0002);
        pulse(0);
        chk(cfg_port_addr, 16'h0370);
        chk(16'(unit_active), 16'h0000);
        chk(unit_base0[15:0], 16'h0000);
        chk(16'(kbc_reset), 16'h0001);
        pulse(1);
        chk(16'(kbc_reset), 16'h0000);
        chk(cfg_port_addr, 16'h0370);
        @(posedge ref_clk) addr_strap <= 1'b1;
        repeat (4) @(posedge ref_clk);
        pulse(2);
        chk(cfg_port_addr, 16'h004e);
        host_model_inst.port = 16'h004e;
        host_model_inst.wr_reg(8'h07, 8'h05);
        chk(16'(unit_number), 16'h0005);
        final_report;
    end
endmodule
